/* logic/tsoc_regs.svh */
// Register offsets, field positions and reset values of the timer event and compare block.
`ifndef TSOC_REGS_SVH
`define TSOC_REGS_SVH
`define TSOC_OFS_SWEVT 5'h00
`define TSOC_OFS_MODE1 5'h04
`define TSOC_OFS_CMP1 5'h08
`define TSOC_OFS_CMP2 5'h0C
`define TSOC_OFS_STS 5'h10
`define TSOC_OFS_POL 5'h14
`define TSOC_SW_OVF_BIT 0
`define TSOC_SW_CH_LSB 1
`define TSOC_SW_TRG_BIT 6
`define TSOC_CFG_LSB 0
`define TSOC_FAST_BIT 2
`define TSOC_BUF_BIT 3
`define TSOC_OCTRL_LSB 4
`define TSOC_CLR_EN_BIT 7
`define TSOC_CH_STRIDE 8
`define TSOC_TRGF_BIT 6
`define TSOC_MODE_RESET 16'h0000
`define TSOC_CMP_RESET 16'h0000
`define TSOC_POL_RESET 2'h0
`endif

/* logic/tsoc_pkg.sv */
// Types shared by the timer event and compare block.
`default_nettype none
package tsoc_pkg;
  typedef enum logic [2:0] {
    OC_OFF, OC_SET, OC_CLR, OC_TGL, OC_LOW, OC_HIGH, OC_PWMA, OC_PWMB
  } tsoc_mode_e;
  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } tsoc_avs_s;
  typedef struct packed {
    logic [15:0] counter;
    logic count_direction;
    logic trigger_event;
    logic overflow_event;
    logic outside_clear_input;
    logic ch1_own_filtered_input;
    logic ch2_filtered_to_ch1;
    logic ch2_own_filtered_input;
    logic ch1_filtered_to_ch2;
    logic internal_trigger_input;
  } tsoc_tmr_s;
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [15:0] mode_reg;
    logic [1:0] pol;
    logic trig_flag;
    logic trg_evt;
    logic ovf_evt;
    logic [3:0] ch_evt;
    logic [1:0][15:0] cmp_act;
    logic [1:0][15:0] cmp_shd;
    logic [1:0] lvl;
    logic [1:0] raw;
  } tsoc_state_s;
endpackage
`default_nettype wire

/* logic/tsoc_top.sv */
// Software event generation and output compare for two timer channels.
`timescale 1ns/100ps
`default_nettype none
`include "tsoc_regs.svh"

module tsoc_top (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire tsoc_pkg::tsoc_avs_s i_avs,
  output logic o_avs_waitrequest,
  output logic [31:0] o_avs_readdata,
  input wire tsoc_pkg::tsoc_tmr_s i_tmr,
  output logic o_trigger_event,
  output logic o_overflow_event,
  output logic [3:0] o_channel_event,
  output logic o_trigger_flag,
  output logic [1:0] o_ch_raw_output,
  output logic [1:0] o_ch_output_signal,
  output logic [1:0] o_ch_output_connected,
  output logic [1:0] o_ch_input
);
  import tsoc_pkg::*;

  // ********************************
  // Functions.
  // ********************************
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  function automatic logic pwm_level(input logic [2:0] mode, input logic dir,
                                     input logic [15:0] cmp, input logic [15:0] cnt);
    logic a;
    a = dir ? !(cmp < cnt) : (cmp > cnt);
    case (mode)
      OC_PWMA: pwm_level = a;
      OC_PWMB: pwm_level = !a;
      default: pwm_level = 1'b0;
    endcase
  endfunction

  function automatic logic sel_input(input logic [1:0] cfg, input logic own,
                                     input logic nbr, input logic itr);
    case (cfg)
      2'h1: sel_input = own;
      2'h2: sel_input = nbr;
      2'h3: sel_input = itr;
      default: sel_input = 1'b0;
    endcase
  endfunction

  // ********************************
  // Bus decode.
  // ********************************
  tsoc_state_s q;
  tsoc_state_s d;
  logic req;
  logic take;
  logic wr_take;
  logic [4:0] addr;
  logic [31:0] wd;
  logic trig;
  logic ovf;

  assign req = i_avs.read | i_avs.write;
  assign take = req & q.ack;
  assign wr_take = take & i_avs.write;
  assign addr = {i_avs.address[4:2], 2'h0};
  assign wd = i_avs.writedata;
  assign trig = i_tmr.trigger_event | q.trg_evt;
  assign ovf = i_tmr.overflow_event | q.ovf_evt;

  // ********************************
  // Next state.
  // ********************************
  always_comb begin
    logic [7:0] f;
    logic [2:0] mode;
    logic match;
    logic [15:0] v;
    f = 8'h00;
    mode = 3'h0;
    match = 1'b0;
    v = 16'h0000;
    d = q;
    d.ack = req & ~q.ack;
    d.trg_evt = 1'b0;
    d.ovf_evt = 1'b0;
    d.ch_evt = 4'h0;
    if (wr_take && addr == `TSOC_OFS_SWEVT && i_avs.byteenable[0]) begin
      d.trg_evt = wd[`TSOC_SW_TRG_BIT];
      d.ovf_evt = wd[`TSOC_SW_OVF_BIT];
      d.ch_evt = wd[`TSOC_SW_CH_LSB +: 4];
    end
    if (wr_take && addr == `TSOC_OFS_MODE1) begin
      d.mode_reg = merge16(q.mode_reg, wd[15:0], i_avs.byteenable[1:0]);
    end
    if (wr_take && addr == `TSOC_OFS_POL && i_avs.byteenable[0]) begin
      d.pol = wd[1:0];
    end
    if (wr_take && addr == `TSOC_OFS_STS && i_avs.byteenable[0] && !wd[`TSOC_TRGF_BIT]) begin
      d.trig_flag = 1'b0;
    end
    if (trig) begin
      d.trig_flag = 1'b1;
    end
    for (int i = 0; i < 2; i++) begin
      f = q.mode_reg[i*`TSOC_CH_STRIDE +: 8];
      mode = f[`TSOC_OCTRL_LSB +: 3];
      if (ovf && f[`TSOC_BUF_BIT]) begin
        d.cmp_act[i] = q.cmp_shd[i];
      end
      if (wr_take && addr == (i == 0 ? `TSOC_OFS_CMP1 : `TSOC_OFS_CMP2)) begin
        v = merge16(q.cmp_shd[i], wd[15:0], i_avs.byteenable[1:0]);
        d.cmp_shd[i] = v;
        if (!f[`TSOC_BUF_BIT]) begin
          d.cmp_act[i] = v;
        end
      end
      match = (i_tmr.counter == q.cmp_act[i]);
      d.lvl[i] = pwm_level(mode, i_tmr.count_direction, q.cmp_act[i], i_tmr.counter);
      case (mode)
        OC_SET: begin
          if (match) begin
            d.raw[i] = 1'b1;
          end
        end
        OC_CLR: begin
          if (match) begin
            d.raw[i] = 1'b0;
          end
        end
        OC_TGL: begin
          if (match) begin
            d.raw[i] = !q.raw[i];
          end
        end
        OC_LOW: d.raw[i] = 1'b0;
        OC_HIGH: d.raw[i] = 1'b1;
        OC_PWMA, OC_PWMB: begin
          d.raw[i] = q.lvl[i];
          if (f[`TSOC_FAST_BIT] && trig) begin
            d.raw[i] = (mode == OC_PWMA) ^ i_tmr.count_direction;
          end
        end
        default: d.raw[i] = q.raw[i];
      endcase
      if (f[`TSOC_CLR_EN_BIT] && i_tmr.outside_clear_input) begin
        d.raw[i] = 1'b0;
      end
      if (f[`TSOC_CFG_LSB +: 2] == 2'h0 && match) begin
        d.ch_evt[i] = 1'b1;
      end
    end
    if (req && !q.ack) begin
      case (addr)
        `TSOC_OFS_MODE1: d.rdata = {16'h0000, q.mode_reg};
        `TSOC_OFS_CMP1: d.rdata = {16'h0000, q.cmp_act[0]};
        `TSOC_OFS_CMP2: d.rdata = {16'h0000, q.cmp_act[1]};
        `TSOC_OFS_STS: d.rdata = {25'h0, q.trig_flag, 6'h00};
        `TSOC_OFS_POL: d.rdata = {30'h0, q.pol};
        default: d.rdata = 32'h00000000;
      endcase
    end
  end

  // ********************************
  // State register.
  // ********************************
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      q <= '0;
      q.mode_reg <= `TSOC_MODE_RESET;
      q.pol <= `TSOC_POL_RESET;
      q.cmp_act <= {2{`TSOC_CMP_RESET}};
      q.cmp_shd <= {2{`TSOC_CMP_RESET}};
    end else begin
      q <= d;
    end
  end

  // ********************************
  // Outputs.
  // ********************************
  assign o_avs_waitrequest = req & ~q.ack;
  assign o_avs_readdata = q.rdata;
  assign o_trigger_event = q.trg_evt;
  assign o_overflow_event = q.ovf_evt;
  assign o_channel_event = q.ch_evt;
  assign o_trigger_flag = q.trig_flag;
  assign o_ch_raw_output = q.raw;
  for (genvar g = 0; g < 2; g++) begin : g_out
    assign o_ch_output_connected[g] = q.mode_reg[g*8+4 +: 3] != OC_OFF;
    assign o_ch_output_signal[g] = o_ch_output_connected[g] & (q.raw[g] ^ q.pol[g]);
  end
  assign o_ch_input[0] = sel_input(q.mode_reg[1:0], i_tmr.ch1_own_filtered_input,
                                   i_tmr.ch2_filtered_to_ch1, i_tmr.internal_trigger_input);
  assign o_ch_input[1] = sel_input(q.mode_reg[9:8], i_tmr.ch2_own_filtered_input,
                                   i_tmr.ch1_filtered_to_ch2, i_tmr.internal_trigger_input);

  // ********************************
  // Assertions.
  // ********************************
  logic [2:0] mode1;
  assign mode1 = q.mode_reg[6:4];

  sequence sw_wr_s(int b);
    wr_take && addr == `TSOC_OFS_SWEVT && i_avs.byteenable[0] && wd[b];
  endsequence

  sequence fast_trig_s;
    mode1 == OC_PWMA && q.mode_reg[2] && !i_tmr.count_direction && trig;
  endsequence

  sw_trig_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    sw_wr_s(6) |=> o_trigger_event ##1 !o_trigger_event) else $error("no trigger pulse");
  sw_ch1_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    sw_wr_s(1) |=> o_channel_event[0]) else $error("no channel 1 pulse");
  sw_ovf_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    sw_wr_s(0) |=> o_overflow_event ##1 !o_overflow_event) else $error("no overflow pulse");
  sw_ch4_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    sw_wr_s(4) |=> o_channel_event[3] ##1 !o_channel_event[3]) else $error("no ch4 pulse");
  outside_clear_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    q.mode_reg[7] && i_tmr.outside_clear_input |=> !o_ch_raw_output[0])
    else $error("outside clear ignored");
  force_low_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    mode1 == OC_LOW |=> !o_ch_raw_output[0]) else $error("force low failed");
  set_match_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    mode1 == OC_SET && i_tmr.counter == q.cmp_act[0] && !q.mode_reg[7] |=> o_ch_raw_output[0])
    else $error("set on match failed");
  buf_load_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    q.mode_reg[3] && ovf && !wr_take |=> q.cmp_act[0] == $past(q.cmp_shd[0]))
    else $error("shadow not moved");
  trig_flag_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    trig |=> o_trigger_flag) else $error("trigger flag not set");
  fast_out_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    fast_trig_s and !q.mode_reg[7] |=> o_ch_raw_output[0]) else $error("fast output late");
endmodule
`default_nettype wire

/* verif/tsoc_top_tb.sv */
// Self-checking bench for the timer event and compare block.
`timescale 1ns/100ps
`default_nettype none
module tsoc_top_tb;
  import tsoc_pkg::*;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  tsoc_avs_s avs = '0;
  tsoc_tmr_s tmr = '{counter: 16'h1234, default: '0};
  logic wq, te, oe, tf, r, p;
  logic [31:0] rd, q;
  logic [3:0] ce;
  logic [1:0] raw, sig, con, inp, g;
  logic [15:0] c;
  logic [2:0] m;
  logic [2:0] ms [7] = '{3'h1, 3'h2, 3'h3, 3'h3, 3'h4, 3'h5, 3'h0};
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  int h;

  always #5 i_clk = ~i_clk;

  tsoc_top tsoc_top_inst (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_avs(avs), .o_avs_waitrequest(wq),
    .o_avs_readdata(rd), .i_tmr(tmr), .o_trigger_event(te), .o_overflow_event(oe),
    .o_channel_event(ce), .o_trigger_flag(tf), .o_ch_raw_output(raw),
    .o_ch_output_signal(sig), .o_ch_output_connected(con), .o_ch_input(inp));

  function automatic logic pwm(input logic [2:0] md, input logic d, input logic [15:0] cv,
                               input logic [15:0] n);
    return (d ? !(cv < n) : (cv > n)) ^ md[0];
  endfunction

  function automatic logic sel(input logic [1:0] cf, input logic own, input logic nb,
                               input logic it);
    return (cf == 2'h1) ? own : (cf == 2'h2) ? nb : (cf == 2'h3) ? it : 1'b0;
  endfunction

  function automatic logic oc(input logic [2:0] md, input logic rv);
    case (md)
      3'h1, 3'h5: return 1'b1;
      3'h2, 3'h4: return 1'b0;
      3'h3: return !rv;
      default: return rv;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task results;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Avalon request held until waitrequest is seen low at a rising edge.
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge i_clk);
    avs <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hF};
    @(posedge i_clk);
    while (wq !== 1'b0) @(posedge i_clk);
    q = rd;
    avs <= '0;
  endtask

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail = n_fail + 1;
      results();
    end
  end

  // ****************************************
  // Main sequence.
  // ****************************************
  initial begin
    void'($urandom(23));
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    bus(1'b1, 5'h18, 32'hFFFF);
    for (int a = 0; a < 7; a++) begin
      bus(1'b0, 5'(a * 4), 32'h0);
      chk("reset", q, 32'h0);
    end
    for (int b = 0; b < 16; b++) begin
      bus(1'b1, 5'h00, 32'h1 << b);
      #1;
      chk("trg", te, b == 6);
      chk("ovf", oe, b == 0);
      chk("chev", ce, (b >= 1 && b <= 4) ? 4'h1 << (b - 1) : 4'h0);
      @(posedge i_clk);
      #1;
      chk("pulse", {te, oe, ce}, 32'h0);
    end
    bus(1'b0, 5'h10, 32'h0);
    chk("flag", q, 32'h40);
    bus(1'b1, 5'h10, 32'h0);
    bus(1'b0, 5'h10, 32'h0);
    chk("flagclr", q, 32'h0);
    c = 16'($urandom_range(16'h0FFF, 16'h0));
    p = 1'($urandom);
    r = 1'b0;
    bus(1'b1, 5'h08, 32'(c));
    bus(1'b1, 5'h14, 32'(p));
    foreach (ms[i]) begin
      bus(1'b1, 5'h04, 32'(ms[i]) << 4);
      tmr.counter <= c;
      @(posedge i_clk);
      tmr.counter <= c + 16'h1;
      repeat (2) @(posedge i_clk);
      #1;
      r = oc(ms[i], r);
      chk("raw", raw[0], r);
      chk("conn", con[0], ms[i] != 3'h0);
      chk("sig", sig[0], (ms[i] != 3'h0) & (r ^ p));
    end
    for (int en = 0; en < 2; en++) begin
      bus(1'b1, 5'h04, en ? 32'hD0 : 32'h50);
      tmr.outside_clear_input <= 1'b1;
      repeat (2) @(posedge i_clk);
      #1;
      chk("clear", raw[0], !en);
      @(posedge i_clk);
      tmr.outside_clear_input <= 1'b0;
    end
    bus(1'b1, 5'h14, 32'h0);
    for (int k = 0; k < 12; k++) begin
      h = k % 2;
      m = 3'h6 + 3'(k / 2 % 2);
      c = 16'($urandom);
      bus(1'b1, h ? 5'h0C : 5'h08, 32'(c));
      bus(1'b1, 5'h04, 32'(m) << (4 + 8 * h));
      tmr.counter <= (k < 4) ? c : 16'($urandom);
      tmr.count_direction <= 1'($urandom);
      repeat (3) @(posedge i_clk);
      #1;
      chk("pwm", raw[h], pwm(m, tmr.count_direction, c, tmr.counter));
    end
    bus(1'b1, 5'h08, 32'h0100);
    tmr.counter <= 16'h0200;
    tmr.count_direction <= 1'b0;
    for (int f = 0; f < 2; f++) begin
      bus(1'b1, 5'h04, f ? 32'h64 : 32'h60);
      repeat (3) @(posedge i_clk);
      tmr.trigger_event <= 1'b1;
      @(posedge i_clk);
      tmr.trigger_event <= 1'b0;
      #1;
      chk("fast", raw[0], f);
    end
    chk("hwflag", tf, 1'b1);
    bus(1'b1, 5'h04, 32'h08);
    bus(1'b1, 5'h08, 32'hA5A5);
    bus(1'b0, 5'h08, 32'h0);
    chk("shadow", q, 32'h0100);
    bus(1'b1, 5'h00, 32'h1);
    bus(1'b0, 5'h08, 32'h0);
    chk("swmove", q, 32'hA5A5);
    bus(1'b1, 5'h08, 32'h5A5A);
    tmr.overflow_event <= 1'b1;
    @(posedge i_clk);
    tmr.overflow_event <= 1'b0;
    bus(1'b0, 5'h08, 32'h0);
    chk("hwmove", q, 32'h5A5A);
    bus(1'b1, 5'h04, 32'h0);
    bus(1'b1, 5'h08, 32'h1111);
    bus(1'b0, 5'h08, 32'h0);
    chk("direct", q, 32'h1111);
    for (int k = 0; k < 16; k++) begin
      g = 2'(k);
      bus(1'b1, 5'h04, {22'h0, g, 6'h0, g});
      {tmr.ch1_own_filtered_input, tmr.ch2_filtered_to_ch1, tmr.ch2_own_filtered_input,
       tmr.ch1_filtered_to_ch2, tmr.internal_trigger_input} <= 5'($urandom);
      @(posedge i_clk);
      #1;
      chk("insel", inp, {sel(g, tmr.ch2_own_filtered_input, tmr.ch1_filtered_to_ch2,
          tmr.internal_trigger_input), sel(g, tmr.ch1_own_filtered_input,
          tmr.ch2_filtered_to_ch1, tmr.internal_trigger_input)});
    end
    results();
  end
endmodule
`default_nettype wire
